// [rtl/multiply_accumulate_element.sv]
// Purpose: Multiplier / multiply-accumulate element with result buffer
// Assumes: All inputs synchronous to mclk_in
// Notes:   Whole pipeline stalls while the result buffer is full
//
// Behaviour
// [RULE1] Signed or unsigned operands chosen each cycle
// [RULE2] Add or subtract product chosen each cycle
// [RULE3] Parallel or serial operand loading, switchable
// [RULE4] Multiply mode outputs only the product
// [RULE5] Multiply mode stages each registered or bypassed
// [RULE6] Accumulate mode adds product to stored total
// [RULE7] Accumulate mode output register always present
// [RULE8] Running total loadable at run time
// [RULE9] Overflow flag registered with the total
// [RULE10] Overflow on unrepresentable result, cleared on load
// [RULE11] Driver holds inputs stable while sampled
`timescale 1ns/1ns
`default_nettype none
`include "mae_map.svh"

// Result buffer: flop storage plus a registered head word
module mae_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         mclk_in,
  input  wire logic         resetn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D+1);
  // All buffer state
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;   // Storage words
    logic [PW-1:0]       wp;    // Write index
    logic [PW-1:0]       rp;    // Read index
    logic [CW-1:0]       cnt;   // Words held in storage
    logic                rdy;   // Space for one more word
    logic                ov;    // Head word valid
    logic [W-1:0]        od;    // Head word
  } fifo_state_s;
  fifo_state_s st_r, st_nxt;
  logic push, pop;

  // Next state: push behind, refill head when it is empty or taken
  always_comb begin
    st_nxt = st_r;
    push   = in_valid_in && st_r.rdy;
    pop    = (st_r.cnt != '0) && (!st_r.ov || out_ready_in);
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data_in;
      st_nxt.wp           = st_r.wp + PW'(1);
    end
    if (pop) begin
      st_nxt.od = st_r.mem[st_r.rp];
      st_nxt.rp = st_r.rp + PW'(1);
    end
    if (pop) begin
      st_nxt.ov = 1'b1;
    end else if (out_ready_in) begin
      st_nxt.ov = 1'b0;
    end
    st_nxt.cnt = st_r.cnt + CW'(push) - CW'(pop);
    st_nxt.rdy = (st_nxt.cnt != CW'(D));
  end

  // State register
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r     <= '0;
      st_r.rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready_out  = st_r.rdy;
  assign out_valid_out = st_r.ov;
  assign out_data_out  = st_r.od;
endmodule : mae_fifo

// Datapath top
module multiply_accumulate_element (
  input  wire logic                   mclk_in,
  input  wire logic                   resetn_in,
  input  wire mae_pkg::cfg_s          cfg_in,        // Static configuration
  input  wire logic                   op_valid_in,   // Operand beat offered
  output logic                        op_ready_out,  // Beat taken when high
  input  wire logic [`MAE_OP_W-1:0]   a_in,          // Parallel operand A
  input  wire logic [`MAE_OP_W-1:0]   b_in,          // Parallel operand B
  input  wire logic                   a_bit_in,      // Serial bit of A
  input  wire logic                   b_bit_in,      // Serial bit of B
  input  wire logic                   signed_in,     // Two's complement operands
  input  wire logic                   sub_in,        // Subtract product
  input  wire logic                   load_in,       // Load running total
  input  wire logic [`MAE_ACC_W-1:0]  load_val_in,   // Value loaded
  output logic [`MAE_ACC_W-1:0]       acc_out,       // Output register
  output logic                        ovf_out,       // Registered overflow
  output logic                        res_valid_out, // Buffered result valid
  input  wire logic                   res_ready_in,  // Result consumer ready
  output mae_pkg::res_s               res_out        // Buffered result
);
  import mae_pkg::*;

  // All element state
  typedef struct packed {
    logic [`MAE_OP_W-1:0]  sh_a;  // Serial shift chain A
    logic [`MAE_OP_W-1:0]  sh_b;  // Serial shift chain B
    op_s                   s1;    // Input register
    prod_s                 s2;    // Pipeline register
    logic                  v3;    // Output register holds a new result
    res_s                  acc;   // Output register
  } mae_state_s;
  mae_state_s st_r, st_nxt;

  logic                    adv;       // Whole pipeline advances
  logic                    take;      // Operand beat accepted
  logic                    load_take; // Total load accepted
  op_s                     op_w;      // Beat entering input stage
  op_s                     s1_w;      // Input stage output
  prod_s                   prod_w;    // Product before pipeline stage
  prod_s                   s2_w;      // Pipeline stage output
  logic [`MAE_OP_W:0]      ea, eb;    // Operands extended by signedness
  logic [2*`MAE_OP_W+1:0]  full_p;    // Extended product
  logic [`MAE_ACC_W-1:0]   pext;      // Product widened to accumulator
  res_s                    base;      // Total and flag before this step
  logic [`MAE_ACC_W:0]     be, pe;    // Widened operands of the sum
  logic [`MAE_ACC_W:0]     sum;       // Accumulation result
  logic                    ovf_now;   // This step overflowed
  logic                    push;      // Result into buffer
  res_s                    push_d;    // Result word pushed
  logic                    fifo_rdy;  // Buffer space

  assign adv       = fifo_rdy;
  assign take      = op_valid_in && adv;
  assign load_take = load_in && adv;

  // Operand selection: parallel inputs or serial chains
  always_comb begin
    op_w.v   = take;
    op_w.sgn = signed_in;
    op_w.sub = sub_in;
    if (cfg_in.serial_load) begin
      op_w.a = {st_r.sh_a[`MAE_OP_W-2:0], a_bit_in}; // RULE3
      op_w.b = {st_r.sh_b[`MAE_OP_W-2:0], b_bit_in}; // RULE3
    end else begin
      op_w.a = a_in;
      op_w.b = b_in;
    end
  end

  // Input stage bypass; driver keeps inputs steady when sampled
  assign s1_w = cfg_in.in_reg ? st_r.s1 : op_w; // RULE5 RULE11

  // Multiplier with per-beat signedness
  always_comb begin
    ea          = {s1_w.sgn & s1_w.a[`MAE_OP_W-1], s1_w.a}; // RULE1
    eb          = {s1_w.sgn & s1_w.b[`MAE_OP_W-1], s1_w.b}; // RULE1
    full_p      = $signed(ea) * $signed(eb);
    prod_w.v    = s1_w.v;
    prod_w.sgn  = s1_w.sgn;
    prod_w.sub  = s1_w.sub;
    prod_w.p    = full_p[`MAE_PROD_W-1:0];
  end

  // Pipeline stage bypass
  assign s2_w = cfg_in.pipe_reg ? st_r.s2 : prod_w; // RULE5

  // Accumulator adder, add or subtract, with overflow
  always_comb begin
    pext = {{`MAE_EXT_W{s2_w.sgn & s2_w.p[`MAE_PROD_W-1]}}, s2_w.p};
    if (load_take) begin
      base.value = load_val_in; // RULE8
      base.ovf   = 1'b0;        // RULE10
    end else begin
      base = st_r.acc;
    end
    be = {s2_w.sgn & base.value[`MAE_ACC_W-1], base.value};
    pe = {s2_w.sgn & pext[`MAE_ACC_W-1], pext};
    if (s2_w.sub) begin
      sum = be - pe; // RULE2
    end else begin
      sum = be + pe; // RULE6
    end
    if (s2_w.sgn) begin
      ovf_now = sum[`MAE_ACC_W] ^ sum[`MAE_ACC_W-1]; // RULE10
    end else begin
      ovf_now = sum[`MAE_ACC_W]; // RULE10
    end
  end

  // Next state of all registers
  always_comb begin
    st_nxt = st_r;
    if (adv) begin
      if (take && cfg_in.serial_load) begin
        st_nxt.sh_a = op_w.a; // RULE3
        st_nxt.sh_b = op_w.b; // RULE3
      end
      st_nxt.s1 = op_w;
      st_nxt.s2 = prod_w;
      st_nxt.v3 = 1'b0;
      if (cfg_in.mac_mode) begin
        // Output register always used in accumulate mode
        st_nxt.acc = base; // RULE7 RULE8
        if (s2_w.v) begin
          st_nxt.acc.value = sum[`MAE_ACC_W-1:0]; // RULE6
          st_nxt.acc.ovf   = base.ovf | ovf_now;  // RULE9 RULE10
          st_nxt.v3        = 1'b1;                // RULE7
        end
      end else if (cfg_in.out_reg && s2_w.v) begin
        st_nxt.acc.value = pext; // RULE4 RULE5
        st_nxt.acc.ovf   = 1'b0;
        st_nxt.v3        = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Buffer feed: registered output, or raw product when bypassed
  always_comb begin
    if (cfg_in.mac_mode || cfg_in.out_reg) begin
      push   = st_r.v3;
      push_d = st_r.acc;
    end else begin
      push         = s2_w.v && adv; // RULE4 RULE5
      push_d.value = pext;          // RULE4
      push_d.ovf   = 1'b0;
    end
  end

  mae_fifo #(
    .W ($bits(res_s)),
    .D (`MAE_FIFO_D)
  ) mae_fifo_i (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_rdy),
    .in_data_in    (push_d),
    .out_valid_out (res_valid_out),
    .out_ready_in  (res_ready_in),
    .out_data_out  (res_out)
  );

  assign op_ready_out = fifo_rdy;
  assign acc_out      = st_r.acc.value;
  assign ovf_out      = st_r.acc.ovf;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  a_unsigned_prod: assert property (s1_w.v && !s1_w.sgn |-> // RULE1
    prod_w.p == {{`MAE_OP_W{1'b0}}, s1_w.a} * {{`MAE_OP_W{1'b0}}, s1_w.b})
    else $error("unsigned product wrong");
  a_sub_step: assert property (cfg_in.mac_mode && adv && s2_w.v && s2_w.sub && !load_take // RULE2
    |=> acc_out == $past(st_r.acc.value - pext)) else $error("subtract step wrong");
  a_serial_shift: assert property (take && cfg_in.serial_load // RULE3
    |=> st_r.sh_a == {$past(st_r.sh_a[`MAE_OP_W-2:0]), $past(a_bit_in)}) else $error("serial shift wrong");
  a_mult_direct: assert property (!cfg_in.mac_mode && !cfg_in.out_reg && s2_w.v && adv // RULE4
    |-> push && push_d.value == pext && !push_d.ovf) else $error("product not passed");
  a_in_bypass: assert property (!cfg_in.in_reg && !cfg_in.pipe_reg && take // RULE5
    |-> s2_w.v && s2_w.sub == sub_in) else $error("bypass path broken");
  a_add_step: assert property (cfg_in.mac_mode && adv && s2_w.v && !s2_w.sub && !load_take // RULE6
    |=> acc_out == $past(st_r.acc.value + pext)) else $error("add step wrong");
  a_out_kept: assert property (cfg_in.mac_mode && adv && s2_w.v // RULE7
    |=> st_r.v3 ##1 1'b1) else $error("accumulate output not registered");
  a_total_load: assert property (load_take && cfg_in.mac_mode && !s2_w.v // RULE8
    |=> acc_out == $past(load_val_in) && !ovf_out) else $error("load failed");
  a_ovf_timing: assert property ($rose(ovf_out) |-> $past(adv && s2_w.v && cfg_in.mac_mode)) // RULE9
    else $error("overflow off the total edge");
  a_ovf_sticky: assert property (cfg_in.mac_mode && ovf_out && !load_take && adv // RULE10
    |=> ovf_out) else $error("overflow lost without load");

  c_mac_run: cover property (cfg_in.mac_mode && s2_w.v ##1 s2_w.v && s2_w.sub);
  c_overflow: cover property ($rose(ovf_out));
  c_full_stall: cover property (!fifo_rdy ##1 fifo_rdy);
  c_serial_mult: cover property (!cfg_in.mac_mode && cfg_in.serial_load && take);
endmodule : multiply_accumulate_element
`default_nettype wire

// [common/mae_map.svh]
// Purpose: Named widths and counts for the multiply-accumulate element
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef MAE_MAP_SVH
`define MAE_MAP_SVH
`define MAE_OP_W    18   // Operand width
`define MAE_PROD_W  36   // Product width
`define MAE_ACC_W   52   // Accumulator width
`define MAE_EXT_W   16   // Product sign extension up to accumulator
`define MAE_FIFO_D  16   // Result buffer depth
`define MAE_PTR_W   4    // Result buffer index width
`define MAE_CNT_W   5    // Result buffer fill count width
`endif

// [common/mae_pkg.sv]
// Purpose: Types shared by the multiply-accumulate element
// Assumes: mae_map.svh gives all widths
// Notes:   Types only
`include "mae_map.svh"
package mae_pkg;
  // Static configuration bits
  typedef struct packed {
    logic mac_mode;     // 1: accumulate, 0: plain multiply
    logic in_reg;       // Input stage registered
    logic pipe_reg;     // Pipeline stage registered
    logic out_reg;      // Output stage registered (multiply only)
    logic serial_load;  // Operands shifted in one bit per beat
  } cfg_s;
  // Input stage contents
  typedef struct packed {
    logic                  v;
    logic                  sgn;
    logic                  sub;
    logic [`MAE_OP_W-1:0]  a;
    logic [`MAE_OP_W-1:0]  b;
  } op_s;
  // Pipeline stage contents
  typedef struct packed {
    logic                   v;
    logic                   sgn;
    logic                   sub;
    logic [`MAE_PROD_W-1:0] p;
  } prod_s;
  // One result word
  typedef struct packed {
    logic                  ovf;
    logic [`MAE_ACC_W-1:0] value;
  } res_s;
endpackage : mae_pkg

// [tb/fabric_sink.sv]
// Purpose: Result consumer standing in the fabric past the buffer
// Assumes: One clock, reset active low
// Notes:   Ready may stall fully or pulse every second cycle
`timescale 1ns/1ns
`default_nettype none
module fabric_sink (
  input  wire logic mclk_in,
  input  wire logic resetn_in,
  input  wire logic stall_in,     // Refuse all results
  input  wire logic slow_in,      // Take every second cycle
  output logic      res_ready_out // Consumer ready
);
  logic tog_r; // Alternates each cycle
  // Pacing flop for slow mode
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) tog_r <= 1'b0;
    else tog_r <= ~tog_r;
  end
  // Ready follows the stall and pacing choices
  assign res_ready_out = !stall_in && (!slow_in || tog_r);
endmodule : fabric_sink
`default_nettype wire

// [tb/tb_multiply_accumulate_element.sv]
// Purpose: Self-checking bench of the multiply-accumulate element
// Assumes: Results leave in beat order, one per beat
// Notes:   Serial results count only once both chains are refilled
`timescale 1ns/1ns
`default_nettype none
`include "mae_map.svh"
module tb_multiply_accumulate_element;
  import mae_pkg::*;
  logic mclk = 0, resetn = 0, opv = 0, abit = 0, bbit = 0, sgn = 0, sub = 0, ld = 0, stall = 0, slow = 0;
  logic                  taken, ovf_e = 0, op_ready, ovf, rvalid, rready;
  logic [`MAE_OP_W-1:0]  ain = '0, bin = '0, ca = '0, cb = '0;
  logic [`MAE_ACC_W-1:0] lv = '0, acc_e = '0, acc;
  cfg_s                  cfg = '0;
  res_s                  rout, rq[$], eq[$];
  bit                    cq[$];     // Result is checked when set
  int                    num_errors = 0, tests_run = 0, ns = 0;
  // Clock and result capture
  always #4 mclk = ~mclk;
  // Capture on the falling edge, where the handshake and head word are settled
  always @(negedge mclk) if (rvalid === 1'b1 && rready === 1'b1) rq.push_back(rout);
  multiply_accumulate_element multiply_accumulate_element_i (.mclk_in(mclk), .resetn_in(resetn), .cfg_in(cfg),
    .op_valid_in(opv), .op_ready_out(op_ready), .a_in(ain), .b_in(bin), .a_bit_in(abit), .b_bit_in(bbit),
    .signed_in(sgn), .sub_in(sub), .load_in(ld), .load_val_in(lv), .acc_out(acc), .ovf_out(ovf),
    .res_valid_out(rvalid), .res_ready_in(rready), .res_out(rout));
  fabric_sink fabric_sink_i (.mclk_in(mclk), .resetn_in(resetn), .stall_in(stall), .slow_in(slow),
    .res_ready_out(rready));
  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic chk_res(input res_s g, input res_s e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_res
  task automatic chk_n(input int g, input int e);
    tests_run++;
    if (g != e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_n
  // Reference total: sign or zero extension, overflow sticky
  function automatic res_s mac_f(input logic [51:0] t, input logic o, input logic [17:0] a, b, input logic sg, sb);
    logic [35:0] p;
    logic [51:0] e;
    logic [52:0] s;
    if (sg) p = $signed(a) * $signed(b);
    else p = a * b;
    e = sg ? {{16{p[35]}}, p} : {16'h0000, p};
    s = sb ? {sg & t[51], t} - {sg & e[51], e} : {sg & t[51], t} + {sg & e[51], e};
    mac_f.value = s[51:0];
    mac_f.ovf = o | (sg ? s[52] ^ s[51] : s[52]);
  endfunction : mac_f
  // One operand beat, held until taken or maxw checks pass
  task automatic beat(input logic [17:0] a, b, input logic sg, sb, input int maxw);
    res_s r;
    int   w;
    opv <= 1'b1; ain <= a; bin <= b; abit <= a[0]; bbit <= b[0]; sgn <= sg; sub <= sb;
    w = 1;
    @(negedge mclk);
    while (op_ready !== 1'b1 && w < maxw) begin w++; @(negedge mclk); end
    taken = (op_ready === 1'b1);
    @(posedge mclk);
    if (!taken) return;
    ca = {ca[16:0], a[0]};
    cb = {cb[16:0], b[0]};
    ns++;
    if (cfg.mac_mode) begin
      r = mac_f(acc_e, ovf_e, a, b, sg, sb);
      acc_e = r.value;
      ovf_e = r.ovf;
    end else if (cfg.serial_load) r = mac_f('0, 1'b0, ca, cb, sg, 1'b0);
    else r = mac_f('0, 1'b0, a, b, sg, 1'b0);
    eq.push_back(r);
    cq.push_back(!cfg.serial_load || ns >= 18);
  endtask : beat
  task automatic idle();
    opv <= 1'b0;
    @(posedge mclk);
  endtask : idle
  // Output register and sticky flag against the reference, read mid-cycle
  task automatic chk_total();
    idle();
    @(negedge mclk);
    chk_res({ovf, acc}, {ovf_e, acc_e});
    @(posedge mclk);
  endtask : chk_total
  task automatic load(input logic [51:0] v);
    idle();
    ld <= 1'b1; lv <= v;
    @(posedge mclk);
    ld <= 1'b0;
    acc_e = v;
    ovf_e = 1'b0;
  endtask : load
  task automatic set_cfg(input cfg_s c);
    cfg <= c;
    @(posedge mclk);
  endtask : set_cfg
  // Wait for every result, then compare in order
  task automatic drain();
    res_s r, e;
    int   w;
    idle();
    for (w = 0; w < 400 && rq.size() < eq.size(); w++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk_n(rq.size(), eq.size());
    while (rq.size() > 0 && eq.size() > 0) begin
      r = rq.pop_front();
      e = eq.pop_front();
      if (cq.pop_front()) chk_res(r, e);
    end
    rq.delete(); eq.delete(); cq.delete();
  endtask : drain
  // Accumulate with each input/pipe choice, mixed sign and direction
  task automatic test_mac();
    for (int k = 0; k < 4; k++) begin
      set_cfg({1'b1, 2'(k), 2'b00});
      load(52'h0_0000_0000_0010);
      beat(18'h3ffff, 18'h00002, 1'b1, 1'b0, 100);
      beat(18'h3ffff, 18'h00002, 1'b0, 1'b0, 100);
      beat(18'h00005, 18'h3fffd, 1'b1, 1'b1, 100);
      beat(18'h00007, 18'h00003, 1'b0, 1'b1, 100);
      drain();
      chk_total();
    end
  endtask : test_mac
  // Carry, signed overflow, borrow; load clears the sticky flag
  task automatic test_ovf();
    set_cfg(5'h10);
    load(52'hf_ffff_ffff_ffff);
    beat(18'h00001, 18'h00001, 1'b0, 1'b0, 100);
    beat(18'h00000, 18'h00000, 1'b0, 1'b0, 100);
    chk_total();
    load(52'h7_ffff_ffff_ffff);
    beat(18'h00001, 18'h00001, 1'b1, 1'b0, 100);
    chk_total();
    load(52'h0_0000_0000_0000);
    beat(18'h00002, 18'h00003, 1'b0, 1'b1, 100);
    load(52'h0_0000_0000_0005);
    beat(18'h00000, 18'h00000, 1'b1, 1'b0, 100);
    drain();
    chk_total();
  endtask : test_ovf
  // Multiply with all eight register choices, back to back
  task automatic test_mult();
    for (int k = 0; k < 8; k++) begin
      set_cfg({1'b0, 3'(k), 1'b0});
      beat(18'h20001, 18'h1fff0, k[0], 1'b0, 100);
      beat(18'h30000, 18'h00003, ~k[0], 1'b1, 100);
      drain();
    end
  endtask : test_mult
  // Serial chains refilled, then the product of their contents
  task automatic test_serial();
    set_cfg(5'h01);
    ns = 0;
    for (int i = 0; i < 22; i++) beat(18'(i * 5 + 1), 18'(i / 3), 1'(i), 1'b0, 100);
    drain();
  endtask : test_serial
  // Fill the buffer against a stalled consumer, drain it slowly
  task automatic test_fill();
    int n;
    set_cfg(5'h00);
    stall <= 1'b1;
    n = 0;
    do begin
      beat(18'(n), 18'h00005, 1'b0, 1'b0, 1);
      if (taken) n++;
    end while (taken && n < 40);
    stall <= 1'b0;
    slow <= 1'b1;
    chk_n(int'(n > 15 && n < 40), 1);
    drain();
    slow <= 1'b0;
  endtask : test_fill
  // Main sequence
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    test_mac();
    test_ovf();
    test_mult();
    test_serial();
    test_mult();
    test_fill();
    end_of_test();
  end
  // Watchdog well past the expected few hundred cycles
  initial begin
    #400000;
    num_errors++;
    end_of_test();
  end
endmodule : tb_multiply_accumulate_element
`default_nettype wire
